// *** core/ast_defines.vh ***
// Register map, field positions, reset values and timing for the serial transmitter
`ifndef AST_DEFINES_VH
`define AST_DEFINES_VH

// Byte addresses of the registers
`define AST_ADDR_BAUD        4'h0
`define AST_ADDR_CTRL        4'h4
`define AST_ADDR_STAT        4'h8
`define AST_ADDR_DATA        4'hC

// Field positions of control_two_reg
`define AST_CTRL_TX_ON       0
`define AST_CTRL_BREAK       1
`define AST_CTRL_NINE        2
`define AST_CTRL_PAR_EN      3
`define AST_CTRL_PAR_ODD     4
`define AST_CTRL_TX_MASK     5
`define AST_CTRL_DONE_MASK   6
`define AST_CTRL_RX_ON       7
`define AST_CTRL_WIDTH       8

// Field positions of the status register
`define AST_STAT_EMPTY       0
`define AST_STAT_DONE        1

// Widths and reset values
`define AST_DIV_WIDTH        13
`define AST_DIV_RESET        13'h0001
`define AST_CTRL_RESET       8'h00
`define AST_FRAME_8          4'hA
`define AST_FRAME_9          4'hB

// AXI4-Lite responses
`define AST_RESP_OKAY        2'h0
`define AST_RESP_DECERR      2'h3

`endif

// *** core/ast_transmitter.v ***
// Transmit half of the asynchronous serial unit with shared bit-rate divider and AXI4-Lite slave
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ast_defines.vh"

module ast_transmitter
(
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [3:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         serial_out_pin,
    output reg         serial_out_en,
    output reg         bit_tick,
    output reg         rx_enable,
    output reg         tx_irq
);

    reg [`AST_DIV_WIDTH-1:0]  baud_div;
    reg [`AST_DIV_WIDTH-1:0]  baud_cnt;
    reg [`AST_CTRL_WIDTH-1:0] control_two_reg;
    reg [8:0]                 data_port_reg;
    reg                       tx_buffer_empty_flag;
    reg                       tx_done_flag;
    reg                       idle_queued;
    reg                       break_queued;
    reg [10:0]                shifter;
    reg [3:0]                 bits_left;
    reg                       aw_hold;
    reg                       w_hold;
    reg [3:0]                 wr_addr;
    reg [31:0]                wr_data;
    reg [3:0]                 wr_strb;

    wire tx_on_bit      = control_two_reg[`AST_CTRL_TX_ON];
    wire send_break_bit = control_two_reg[`AST_CTRL_BREAK];
    wire nine_bits      = control_two_reg[`AST_CTRL_NINE];
    wire par_en         = control_two_reg[`AST_CTRL_PAR_EN];
    wire par_odd        = control_two_reg[`AST_CTRL_PAR_ODD];
    wire tx_irq_mask    = control_two_reg[`AST_CTRL_TX_MASK];
    wire done_irq_mask  = control_two_reg[`AST_CTRL_DONE_MASK];

    // Register write happens once both address and data are held
    wire do_write  = aw_hold & w_hold;
    wire wr_ctrl   = do_write & (wr_addr == `AST_ADDR_CTRL) & wr_strb[0];
    wire wr_txdata = do_write & (wr_addr == `AST_ADDR_DATA) & wr_strb[0];
    wire wr_mapped = (wr_addr == `AST_ADDR_BAUD) | (wr_addr == `AST_ADDR_CTRL)
                   | (wr_addr == `AST_ADDR_STAT) | (wr_addr == `AST_ADDR_DATA);

    // Modulo divider; a zero divisor stops the tick
    wire tick = (baud_div != {`AST_DIV_WIDTH{1'b0}}) & (baud_cnt == baud_div - 1'b1);

    // Frame construction
    wire [3:0]  frame_len = nine_bits ? `AST_FRAME_9 : `AST_FRAME_8;
    wire        par_bit   = nine_bits ? (^data_port_reg[7:0] ^ par_odd)
                                      : (^data_port_reg[6:0] ^ par_odd);
    reg  [8:0]  data_bits;
    reg  [10:0] data_frame;

    always @*
    begin
        data_bits = data_port_reg;
        if (par_en)
        begin
            if (nine_bits)
                data_bits[8] = par_bit;
            else
                data_bits[7] = par_bit;
        end
        if (nine_bits)
            data_frame = {1'b1, data_bits, 1'b0};
        else
            data_frame = {2'b11, data_bits[7:0], 1'b0};
    end

    // Queued idle beats break, break beats data
    wire shifter_free = (bits_left <= 4'h1);
    wire load_idle    = tick & shifter_free & idle_queued;
    wire load_break   = tick & shifter_free & ~idle_queued & break_queued;
    wire load_data    = tick & shifter_free & ~idle_queued & ~break_queued
                      & ~tx_buffer_empty_flag & tx_on_bit;
    wire stop_done    = tick & (bits_left == 4'h1) & ~load_idle & ~load_break & ~load_data;

    // Bit-rate divider
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            baud_cnt <= {`AST_DIV_WIDTH{1'b0}};
            bit_tick <= 1'b0;
        end
        else
        begin
            if (tick || baud_cnt >= baud_div)
                baud_cnt <= {`AST_DIV_WIDTH{1'b0}};
            else
                baud_cnt <= baud_cnt + 1'b1;
            bit_tick <= tick;
        end
    end

    // Shifter and queued frames
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            shifter      <= 11'h7FF;
            bits_left    <= 4'h0;
            idle_queued  <= 1'b0;
            break_queued <= 1'b0;
        end
        else
        begin
            if (load_idle)
            begin
                shifter   <= 11'h7FF;
                bits_left <= frame_len;
            end
            else if (load_break)
            begin
                shifter   <= 11'h000;
                bits_left <= frame_len;
            end
            else if (load_data)
            begin
                shifter   <= data_frame;
                bits_left <= frame_len;
            end
            // Ones enter from the top so the line rests high after a frame
            else if (tick && bits_left != 4'h0)
            begin
                shifter   <= {1'b1, shifter[10:1]};
                bits_left <= bits_left - 1'b1;
            end

            if (wr_ctrl && wr_data[`AST_CTRL_TX_ON] && !tx_on_bit)
                idle_queued <= 1'b1;
            else if (load_idle)
                idle_queued <= 1'b0;

            if (wr_ctrl && wr_data[`AST_CTRL_BREAK] && !send_break_bit)
                break_queued <= 1'b1;
            else if (load_break)
                break_queued <= send_break_bit;
        end
    end

    // Flags, buffer and control register
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            baud_div             <= `AST_DIV_RESET;
            control_two_reg      <= `AST_CTRL_RESET;
            data_port_reg        <= 9'h000;
            tx_buffer_empty_flag <= 1'b1;
            tx_done_flag         <= 1'b1;
        end
        else
        begin
            if (do_write && wr_addr == `AST_ADDR_BAUD)
            begin
                if (wr_strb[0])
                    baud_div[7:0] <= wr_data[7:0];
                if (wr_strb[1])
                    baud_div[12:8] <= wr_data[12:8];
            end
            if (wr_ctrl)
                control_two_reg <= wr_data[`AST_CTRL_WIDTH-1:0];
            if (wr_txdata)
            begin
                data_port_reg[7:0] <= wr_data[7:0];
                if (wr_strb[1])
                    data_port_reg[8] <= wr_data[8];
            end

            if (load_data)
                tx_buffer_empty_flag <= 1'b1;
            else if (wr_txdata && tx_buffer_empty_flag)
                tx_buffer_empty_flag <= 1'b0;

            // A data write beats done so done never shows with a full buffer
            if (stop_done && !wr_txdata && tx_buffer_empty_flag)
                tx_done_flag <= 1'b1;
            else if ((wr_txdata && tx_buffer_empty_flag)
                     || (wr_ctrl && wr_data[`AST_CTRL_TX_ON] && !tx_on_bit)
                     || (wr_ctrl && wr_data[`AST_CTRL_BREAK] && !send_break_bit))
                tx_done_flag <= 1'b0;
        end
    end

    // Pin, enable and request outputs
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            serial_out_pin <= 1'b1;
            serial_out_en  <= 1'b0;
            rx_enable      <= 1'b0;
            tx_irq         <= 1'b0;
        end
        else
        begin
            serial_out_pin <= (bits_left != 4'h0) ? shifter[0] : 1'b1;
            serial_out_en  <= tx_on_bit | (bits_left != 4'h0)
                            | idle_queued | break_queued;
            rx_enable      <= control_two_reg[`AST_CTRL_RX_ON];
            tx_irq         <= (tx_buffer_empty_flag & tx_irq_mask)
                            | (tx_done_flag & done_irq_mask);
        end
    end

    // AXI4-Lite write channels, address and data taken in either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AST_RESP_OKAY;
            aw_hold       <= 1'b0;
            w_hold        <= 1'b0;
            wr_addr       <= 4'h0;
            wr_data       <= 32'h00000000;
            wr_strb       <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold       <= 1'b1;
                wr_addr       <= {s_axi_awaddr[3:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold       <= 1'b1;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? `AST_RESP_OKAY : `AST_RESP_DECERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channels
    // Unaligned addresses alias to the word below
    wire [3:0] rd_addr = {s_axi_araddr[3:2], 2'b00};

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `AST_RESP_OKAY;
        end
        else
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `AST_RESP_OKAY;
                case (rd_addr)
                    `AST_ADDR_BAUD:
                        s_axi_rdata <= {19'h00000, baud_div};
                    `AST_ADDR_CTRL:
                        s_axi_rdata <= {24'h000000, control_two_reg};
                    `AST_ADDR_STAT:
                        s_axi_rdata <= {30'h00000000, tx_done_flag, tx_buffer_empty_flag};
                    `AST_ADDR_DATA:
                        s_axi_rdata <= {23'h000000, data_port_reg};
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `AST_RESP_DECERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// *** testbench/ast_serial_rx.sv ***
// Remote serial receiver model sampling the transmit line mid bit
`timescale 1ns/1ps
`default_nettype none
module ast_serial_rx
#(
    parameter int DIV = 4
)
(
    input  wire logic       aclk,
    input  wire logic       line,
    input  wire logic       nine,
    output var  logic [8:0] data,
    output var  logic       stop,
    output var  int         count
);
    int i;
    initial count = 0;
    always
    begin
        @(posedge aclk);
        if (line === 1'b0)
        begin
            repeat (DIV / 2) @(posedge aclk);
            data = 9'h000;
            for (i = 0; i < (nine ? 9 : 8); i++)
            begin
                repeat (DIV) @(posedge aclk);
                data[i] = line;
            end
            repeat (DIV) @(posedge aclk);
            stop = line;
            count++;
            // Realign to the frame boundary for back-to-back frames
            repeat (DIV / 2 - 1) @(posedge aclk);
        end
    end
endmodule
`default_nettype wire

// *** testbench/ast_transmitter_checker.sv ***
// Port checker for the serial transmitter
`timescale 1ns/1ps
`default_nettype none
module ast_transmitter_checker
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic serial_out_pin,
    input wire logic serial_out_en
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_idle_high;
        !serial_out_en |-> serial_out_pin;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("line low while released");
    property p_en_fall;
        $fell(serial_out_en) |-> serial_out_pin;
    endproperty
    a_en_fall: assert property (p_en_fall) else $error("pin released mid frame");
    property p_rise_high;
        $rose(serial_out_en) |-> serial_out_pin;
    endproperty
    a_rise_high: assert property (p_rise_high) else $error("enable without high line");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_b_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
    endproperty
    a_b_done: assert property (p_b_done) else $error("write response not closed");
    property p_w_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_w_block: assert property (p_w_block) else $error("write taken before response");
    property p_r_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_r_ans: assert property (p_r_ans) else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
endmodule
bind ast_transmitter ast_transmitter_checker chk_u (.*);
`default_nettype wire

// *** testbench/async_serial_transmitter_tb.sv ***
// Self-checking testbench for the serial transmitter
`timescale 1ns/1ps
`default_nettype none
`include "ast_defines.vh"
module async_serial_transmitter_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, nine = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        serial_out_pin, serial_out_en, bit_tick, rx_enable, tx_irq, rx_stop;
    logic [8:0]  rx_data;
    logic [31:0] irq_cfg[3] = '{32'h20, 32'h40, 32'h00};
    int          rx_count, n, mismatches = 0, checks_done = 0;
    always #50 aclk = ~aclk;
    ast_transmitter dut_u (.*);
    wire         line_seen = serial_out_en ? serial_out_pin : 1'b1;
    ast_serial_rx #(.DIV(4)) rx_u (.aclk(aclk), .line(line_seen), .nine(nine),
        .data(rx_data), .stop(rx_stop), .count(rx_count));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        chk("bresp", 32'h0, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] e);
        rd(a);
        chk("register", e, rv);
    endtask
    task automatic rx(input logic [8:0] d, input logic s);
        n = rx_count;
        while (rx_count == n)
            @(posedge aclk);
        chk("rx data", {23'h0, d}, {23'h0, rx_data});
        chk("rx stop", {31'h0, s}, {31'h0, rx_stop});
    endtask
    task automatic wait_low;
        n = 0;
        while (serial_out_pin !== 1'b0)
        begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #(100 * 20000);
        mismatches++;
        summarize();
    end
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(`AST_ADDR_STAT, 32'h3);
        rc(`AST_ADDR_BAUD, 32'h1);
        rd(4'h2);
        chk("resp", 32'h0, {30'h0, resp});
        chk("alias", 32'h1, rv);
        wr(`AST_ADDR_BAUD, 32'h4);
        n = 0;
        repeat (40)
        begin
            @(posedge aclk);
            n += bit_tick;
        end
        chk("ticks", 32'hA, n);
        wr(`AST_ADDR_CTRL, 32'h81);
        chk("rx on", 32'h1, {31'h0, rx_enable});
        wr(`AST_ADDR_DATA, 32'hA5);
        rc(`AST_ADDR_STAT, 32'h0);
        wait_low();
        chk("preamble", 32'h1, {31'h0, n > 16});
        rx(9'h0A5, 1'b1);
        wr(`AST_ADDR_DATA, 32'h3C);
        do rd(`AST_ADDR_STAT); while (rv[0] !== 1'b1);
        wr(`AST_ADDR_DATA, 32'hC3);
        rx(9'h03C, 1'b1);
        rx(9'h0C3, 1'b1);
        repeat (8) @(posedge aclk);
        rc(`AST_ADDR_STAT, 32'h3);
        nine = 1'b1;
        wr(`AST_ADDR_CTRL, 32'h85);
        wr(`AST_ADDR_DATA, 32'h1A5);
        rx(9'h1A5, 1'b1);
        nine = 1'b0;
        wr(`AST_ADDR_CTRL, 32'h89);
        wr(`AST_ADDR_DATA, 32'h07);
        rx(9'h087, 1'b1);
        wr(`AST_ADDR_CTRL, 32'h99);
        wr(`AST_ADDR_DATA, 32'h07);
        rx(9'h007, 1'b1);
        wr(`AST_ADDR_CTRL, 32'h83);
        wr(`AST_ADDR_CTRL, 32'h81);
        rx(9'h000, 1'b0);
        wr(`AST_ADDR_CTRL, 32'h83);
        rx(9'h000, 1'b0);
        rx(9'h000, 1'b0);
        wr(`AST_ADDR_CTRL, 32'h81);
        do rd(`AST_ADDR_STAT); while (rv[1] !== 1'b1);
        wr(`AST_ADDR_DATA, 32'h5A);
        wait_low();
        wr(`AST_ADDR_CTRL, 32'h80);
        chk("drive", 32'h1, {31'h0, serial_out_en});
        wr(`AST_ADDR_CTRL, 32'h81);
        rc(`AST_ADDR_STAT, 32'h1);
        rx(9'h05A, 1'b1);
        wr(`AST_ADDR_DATA, 32'h69);
        wait_low();
        chk("idle gap", 32'h1, {31'h0, n >= 30});
        rx(9'h069, 1'b1);
        wr(`AST_ADDR_CTRL, 32'h80);
        repeat (8) @(posedge aclk);
        chk("released", 32'h0, {31'h0, serial_out_en});
        foreach (irq_cfg[i])
        begin
            wr(`AST_ADDR_CTRL, irq_cfg[i]);
            repeat (2) @(posedge aclk);
            chk("irq", {31'h0, i < 2}, {31'h0, tx_irq});
        end
        wr(`AST_ADDR_CTRL, 32'h20);
        wr(`AST_ADDR_DATA, 32'h11);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h0, {31'h0, tx_irq});
        summarize();
    end
endmodule
`default_nettype wire
